// ---- src/dcc_pkg.sv ----
// Package for the dual comparator control block: offsets, fields, types
package dcc_pkg;

  // ------------------------------------------------------------
  // Register byte addresses on APB
  // ------------------------------------------------------------
  localparam logic [15:0] DCC_REF_IDX      = 16'hFFCB;  // printed offset, used as index
  localparam logic [17:0] DCC_REF_ADDR     = {DCC_REF_IDX, 2'b00};
  localparam logic [17:0] DCC_CTL1_ADDR    = 18'h00000;
  localparam logic [17:0] DCC_CTL2_ADDR    = 18'h00004;
  localparam logic [17:0] DCC_IRQEN_ADDR   = 18'h00008;
  localparam logic [17:0] DCC_PWR_ADDR     = 18'h0000C;
  localparam logic [17:0] DCC_STAT_ADDR    = 18'h00010;
  localparam logic [17:0] DCC_CLR_ADDR     = 18'h00014;
  localparam logic [17:0] DCC_EVEN_ADDR    = 18'h00018;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int DCC_REF1_LSB   = 0;
  localparam int DCC_REF2_LSB   = 4;
  localparam int DCC_CE_BIT     = 5;
  localparam int DCC_CP_BIT     = 4;
  localparam int DCC_CN_BIT     = 3;
  localparam int DCC_OE_BIT     = 2;
  localparam int DCC_CO_BIT     = 1;
  localparam int DCC_CMF_BIT    = 0;
  localparam int DCC_EC_BIT     = 0;
  localparam int DCC_EA_BIT     = 1;
  localparam int DCC_PWRDN_BIT  = 5;
  localparam int DCC_NCMP       = 2;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] DCC_REF_RST   = 8'h00;
  localparam logic [7:0] DCC_REF_MASK  = 8'h77;
  localparam logic [5:0] DCC_CTL_RST   = 6'h00;
  localparam logic [2:0] DCC_BANDGAP   = 3'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       enable;
    logic       pos_sel;
    logic       neg_sel;
    logic       pin_en;
    logic [2:0] ref_code;
  } dcc_cfg_s;

  typedef enum logic [1:0] {
    DCC_RUN      = 2'b00,
    DCC_IDLE     = 2'b01,
    DCC_PDOWN    = 2'b10,
    DCC_TOTAL_PD = 2'b11
  } dcc_pmode_e;

endpackage : dcc_pkg

// ---- src/dcc_channel.sv ----
// One comparator channel: synchroniser, forced-high output, change flag
module dcc_channel
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic enabled,
  input  wire logic flag_clr,
  // Analog core
  input  wire logic raw_out,
  // Results
  output logic      synced_out,
  output logic      flag
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic flag_r;
  logic out_nxt;

  // Two flops before any logic reads the asynchronous core output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw_out;
      sync2_r <= sync1_r;
    end
  end

  // Disabled comparator reads high
  assign out_nxt = enabled ? sync2_r : 1'b1;

  // Previous output; forced high counts as a change too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= out_nxt;
    end
  end

  // Sticky flag, set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (out_nxt != prev_r) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  assign synced_out = prev_r;
  assign flag       = flag_r;

endmodule // dcc_channel

// ---- src/dcc_top.sv ----
// Dual comparator control: APB registers, flags, interrupt, power control
// How it works
// - Bits 2:0 pick comparator one reference
// - Bits 6:4 pick comparator two reference
// - Each comparator has independent reference code
// - Output change either way sets flag
// - Both flags share one interrupt request
// - Interrupt needs comparator and global enables
// - Disabled comparator output reads high
// - Disabling a low output sets flag
// - Total power-down disables both comparators
// - Enabled change wakes processor in idle and power-down only
// - Power removed when disabled and bit five
// - Control bits: enable, selects, pin, output, flag
// - Output bit synchronised to CPU clock
// - Hardware sets flag, only software clears
//
// The implementer's own choice: the APB register port.
module dcc_top
  import dcc_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power mode from the system
  input  wire logic [1:0]  power_mode,
  // Analog comparator cores
  input  wire logic        comp1_raw,
  input  wire logic        comp2_raw,
  output logic             comp1_enable,
  output logic             comp2_enable,
  output logic             comp1_pos_sel,
  output logic             comp2_pos_sel,
  output logic             comp1_neg_sel,
  output logic             comp2_neg_sel,
  output logic             comp1_pin_en,
  output logic             comp2_pin_en,
  output logic [2:0]       first_reference_code,
  output logic [2:0]       second_reference_code,
  output logic             comp_power_off,
  // Interrupts
  output logic             irq,
  output logic             wake
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] ref_r;
  logic [5:2] ctl_r [DCC_NCMP];
  logic [1:0] irqen_r;
  logic       pwr_r;
  logic [1:0] even_r;
  logic [1:0] pmode_sync1_r;
  logic [1:0] pmode_sync2_r;
  logic [1:0] flag;
  logic [1:0] synced_comparator_output;
  logic [1:0] flag_clr;
  logic [1:0] comp_on;
  logic       total_pd;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [31:0] rd_data;
  dcc_pmode_e pmode;

  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite & pready;

  // ------------------------------------------------------------
  // Power mode input synchroniser
  // ------------------------------------------------------------
  // Mode comes from another power controller, so treat it as asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmode_sync1_r <= 2'b00;
      pmode_sync2_r <= 2'b00;
    end else begin
      pmode_sync1_r <= power_mode;
      pmode_sync2_r <= pmode_sync1_r;
    end
  end

  assign pmode    = dcc_pmode_e'(pmode_sync2_r);
  assign total_pd = (pmode == DCC_TOTAL_PD);

  // ------------------------------------------------------------
  // Reference select register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= DCC_REF_RST;
    end else if (wr_en && paddr == DCC_REF_ADDR && pstrb[0]) begin
      ref_r <= pwdata[7:0] & DCC_REF_MASK;
    end
  end

  // ------------------------------------------------------------
  // Comparator control registers (enable, selects, pin enable)
  // ------------------------------------------------------------
  // Total power-down clears the enable so software sees it off afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r[0] <= DCC_CTL_RST[5:2];
      ctl_r[1] <= DCC_CTL_RST[5:2];
    end else begin
      if (wr_en && paddr == DCC_CTL1_ADDR && pstrb[0]) begin
        ctl_r[0] <= pwdata[DCC_CE_BIT:DCC_OE_BIT];
      end
      if (wr_en && paddr == DCC_CTL2_ADDR && pstrb[0]) begin
        ctl_r[1] <= pwdata[DCC_CE_BIT:DCC_OE_BIT];
      end
      if (total_pd) begin
        ctl_r[0][DCC_CE_BIT] <= 1'b0;
        ctl_r[1][DCC_CE_BIT] <= 1'b0;
      end
    end
  end

  // Idle and power-down leave enabled comparators running
  assign comp_on[0] = ctl_r[0][DCC_CE_BIT] & ~total_pd;
  assign comp_on[1] = ctl_r[1][DCC_CE_BIT] & ~total_pd;

  // ------------------------------------------------------------
  // Interrupt enables, power control, event enables
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqen_r <= 2'b00;
      pwr_r   <= 1'b0;
      even_r  <= 2'b00;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == DCC_IRQEN_ADDR) begin
        irqen_r <= {pwdata[DCC_EA_BIT], pwdata[DCC_EC_BIT]};
      end
      if (paddr == DCC_PWR_ADDR) begin
        pwr_r <= pwdata[DCC_PWRDN_BIT];
      end
      if (paddr == DCC_EVEN_ADDR) begin
        even_r <= pwdata[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Flag clears: via control register bit 0 written 0, or clear reg
  // ------------------------------------------------------------
  // Only software clears; the channel lets a new change win
  always_comb begin
    flag_clr = 2'b00;
    if (wr_en && pstrb[0]) begin
      if (paddr == DCC_CTL1_ADDR && !pwdata[DCC_CMF_BIT]) begin
        flag_clr[0] = 1'b1;
      end
      if (paddr == DCC_CTL2_ADDR && !pwdata[DCC_CMF_BIT]) begin
        flag_clr[1] = 1'b1;
      end
      if (paddr == DCC_CLR_ADDR) begin
        flag_clr = flag_clr | pwdata[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Comparator channels
  // ------------------------------------------------------------
  dcc_channel u_ch1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .enabled    (comp_on[0]),
    .flag_clr   (flag_clr[0]),
    .raw_out    (comp1_raw),
    .synced_out (synced_comparator_output[0]),
    .flag       (flag[0])
  );

  dcc_channel u_ch2 (
    .pclk       (pclk),
    .presetn    (presetn),
    .enabled    (comp_on[1]),
    .flag_clr   (flag_clr[1]),
    .raw_out    (comp2_raw),
    .synced_out (synced_comparator_output[1]),
    .flag       (flag[1])
  );

  // ------------------------------------------------------------
  // Interrupt and wake outputs
  // ------------------------------------------------------------
  // One shared request; the status register tells the source apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else begin
      irq  <= |(flag & even_r) & irqen_r[0] & irqen_r[1];
      wake <= |(flag & even_r) & irqen_r[0] & irqen_r[1]
              & (pmode != DCC_RUN) & ~total_pd;
    end
  end

  // ------------------------------------------------------------
  // Analog-facing outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp1_enable          <= 1'b0;
      comp2_enable          <= 1'b0;
      comp1_pos_sel         <= 1'b0;
      comp2_pos_sel         <= 1'b0;
      comp1_neg_sel         <= 1'b0;
      comp2_neg_sel         <= 1'b0;
      comp1_pin_en          <= 1'b0;
      comp2_pin_en          <= 1'b0;
      first_reference_code  <= DCC_BANDGAP;
      second_reference_code <= DCC_BANDGAP;
      comp_power_off        <= 1'b0;
    end else begin
      comp1_enable          <= comp_on[0];
      comp2_enable          <= comp_on[1];
      comp1_pos_sel         <= ctl_r[0][DCC_CP_BIT];
      comp2_pos_sel         <= ctl_r[1][DCC_CP_BIT];
      comp1_neg_sel         <= ctl_r[0][DCC_CN_BIT];
      comp2_neg_sel         <= ctl_r[1][DCC_CN_BIT];
      comp1_pin_en          <= ctl_r[0][DCC_OE_BIT] & comp_on[0];
      comp2_pin_en          <= ctl_r[1][DCC_OE_BIT] & comp_on[1];
      first_reference_code  <= ref_r[DCC_REF1_LSB +: 3];
      second_reference_code <= ref_r[DCC_REF2_LSB +: 3];
      // Total power-down also cuts power, whatever the control bit says
      comp_power_off        <= (~comp_on[0] & ~comp_on[1] & pwr_r) | total_pd;
    end
  end

  // ------------------------------------------------------------
  // APB read mux
  // ------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr)
      DCC_REF_ADDR:   rd_data[7:0] = ref_r;
      DCC_CTL1_ADDR:  rd_data[5:0] = {ctl_r[0], synced_comparator_output[0], flag[0]};
      DCC_CTL2_ADDR:  rd_data[5:0] = {ctl_r[1], synced_comparator_output[1], flag[1]};
      DCC_IRQEN_ADDR: rd_data[1:0] = irqen_r;
      DCC_PWR_ADDR:   rd_data[DCC_PWRDN_BIT] = pwr_r;
      DCC_STAT_ADDR:  rd_data[1:0] = flag;
      DCC_CLR_ADDR:   rd_data = 32'h0000_0000;
      DCC_EVEN_ADDR:  rd_data[1:0] = even_r;
      default:        addr_ok = 1'b0;
    endcase
  end

  // Zero-wait answers; unmapped addresses get an error response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule // dcc_top

// ---- testbench/dcc_chk.sv ----
// Port-level checker for the dual comparator control block
module dcc_chk
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // Comparator side
  input wire logic [1:0]  power_mode,
  input wire logic        comp1_enable,
  input wire logic        comp2_enable,
  input wire logic [2:0]  first_reference_code,
  input wire logic [2:0]  second_reference_code,
  input wire logic        comp_power_off,
  input wire logic        irq,
  input wire logic        wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       acc_wr;
  logic       ref_wr;
  logic [6:0] ref_q;
  // Completed writes; the reference write also needs the low strobe
  assign acc_wr = psel && penable && pready && pwrite;
  assign ref_wr = acc_wr && pstrb[0] && (paddr == DCC_REF_ADDR);
  // Keep the low seven written bits, the code outputs may lag one register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ref_q <= 7'h00;
    else if (ref_wr) ref_q <= pwdata[6:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ref1_write: assert property (ref_wr |-> ##[1:2] first_reference_code == ref_q[2:0])
    else $error("first code differs from write");
  a_ref2_write: assert property (ref_wr |-> ##[1:2] second_reference_code == ref_q[6:4])
    else $error("second code differs from write");
  a_tpd_off: assert property ((power_mode == 2'h3) [*5] |-> !comp1_enable && !comp2_enable)
    else $error("enable kept in total power-down");
  a_power_on: assert property (((comp1_enable || comp2_enable) && power_mode != 2'h3) [*2]
                               |-> !comp_power_off)
    else $error("power removed from enabled core");
  a_wake_run: assert property ((power_mode == 2'h0) [*5] |-> !wake)
    else $error("wake in run mode");
  a_irq_hold: assert property (irq && !acc_wr |=> irq || $past(acc_wr, 2))
    else $error("irq dropped without a write");
endmodule // dcc_chk

bind dcc_top dcc_chk u_dcc_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
  .power_mode, .comp1_enable, .comp2_enable, .first_reference_code,
  .second_reference_code, .comp_power_off, .irq, .wake
);

// ---- testbench/dcc_cores.sv ----
// Behavioural model of the two analog comparator cores
module dcc_cores #(
  parameter int SETTLE = 500
) (
  // Clock
  input  wire logic       pclk,
  // Enables from the block, index 0 is comparator one
  input  wire logic [1:0] en,
  // Analog decision commanded by the bench
  input  wire logic [1:0] lvl,
  // Raw core outputs
  output logic      [1:0] raw
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [2] = '{0, 0};
  initial raw = 2'h0;
  // An off or settling core has no valid decision, so it chatters
  always @(posedge pclk) begin
    for (int i = 0; i < 2; i++) begin
      if (!en[i] || cnt[i] < SETTLE) raw[i] <= ~raw[i];
      else raw[i] <= lvl[i];
      cnt[i] <= en[i] ? cnt[i] + 1 : 0;
    end
  end
endmodule // dcc_cores

// ---- testbench/tb.sv ----
// Self-checking bench for the dual comparator control block
`define CHK(g, x) begin \
  comparisons++; \
  if ((g) !== (x)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %0h want %0h", $time, g, x); \
  end \
end
module tb
  import dcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr      = 18'h00000;
  logic [31:0] pwdata     = 32'h0;
  logic [3:0]  pstrb      = 4'hF;
  logic [1:0]  power_mode = 2'h0;
  logic [1:0]  lvl        = 2'h0;
  logic [1:0]  raw;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, wake, comp_power_off;
  logic        comp1_enable, comp2_enable, comp1_pos_sel, comp2_pos_sel;
  logic        comp1_neg_sel, comp2_neg_sel, comp1_pin_en, comp2_pin_en;
  logic [2:0]  first_reference_code, second_reference_code;
  int          error_cnt = 0, comparisons = 0;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // Block and its analog partner
  dcc_top u_dcc_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .power_mode, .comp1_raw(raw[0]), .comp2_raw(raw[1]), .comp1_enable,
    .comp2_enable, .comp1_pos_sel, .comp2_pos_sel, .comp1_neg_sel, .comp2_neg_sel,
    .comp1_pin_en, .comp2_pin_en, .first_reference_code, .second_reference_code,
    .comp_power_off, .irq, .wake
  );
  dcc_cores u_dcc_cores (.pclk, .en({comp2_enable, comp1_enable}), .lvl, .raw);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic conclude;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; an idle edge first keeps drivers from double assignment
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask
  // Bounded wait for the interrupt level
  task automatic wt(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
    `CHK(irq, v)
    // A wait that ran out ends the run at the closing report
    if (irq !== v) conclude();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Disabled outputs rise out of reset, so both flags are already set
  task automatic s_reset;
    rd(DCC_REF_ADDR, 32'h0, 1'b0);
    rd(DCC_CTL1_ADDR, 32'h3, 1'b0);
    rd(DCC_STAT_ADDR, 32'h3, 1'b0);
    wr(DCC_CLR_ADDR, 32'h3);
    rd(DCC_STAT_ADDR, 32'h0, 1'b0);
    rd(18'h00100, 32'h0, 1'b1);
  endtask
  // Every code, two fields unequal, reserved bits written as ones
  task automatic s_ref;
    for (int c = 0; c < 8; c++) begin
      wr(DCC_REF_ADDR, 32'hFFFFFF88 | 32'(c) | 32'((7 - c) << 4));
      rd(DCC_REF_ADDR, 32'(c) | 32'((7 - c) << 4), 1'b0);
      `CHK(first_reference_code, 3'(c))
      `CHK(second_reference_code, 3'(7 - c))
    end
    pstrb <= 4'hE;
    wr(DCC_REF_ADDR, 32'h11);
    rd(DCC_REF_ADDR, 32'h7, 1'b0);
    pstrb <= 4'hF;
  endtask
  task automatic s_change;
    wr(DCC_CTL1_ADDR, 32'h3C);
    // Control outputs are registered after the register, so look once they settle
    repeat (520) @(posedge pclk);
    `CHK({comp1_enable, comp1_pos_sel, comp1_neg_sel, comp1_pin_en}, 4'hF)
    wr(DCC_CLR_ADDR, 32'h1);
    wr(DCC_EVEN_ADDR, 32'h3);
    wr(DCC_IRQEN_ADDR, 32'h3);
    lvl[0] <= 1'b1;
    wt(1'b1);
    rd(DCC_STAT_ADDR, 32'h1, 1'b0);
    rd(DCC_CTL1_ADDR, 32'h3F, 1'b0);
    wr(DCC_CTL1_ADDR, 32'h3C);
    wt(1'b0);
    lvl[0] <= 1'b0;
    wt(1'b1);
    wr(DCC_CLR_ADDR, 32'h1);
    wt(1'b0);
    wr(DCC_IRQEN_ADDR, 32'h1);
    lvl[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(irq, 1'b0)
    rd(DCC_STAT_ADDR, 32'h1, 1'b0);
    lvl[0] <= 1'b0;
    wr(DCC_IRQEN_ADDR, 32'h0);
    wr(DCC_CLR_ADDR, 32'h1);
    wr(DCC_CTL1_ADDR, 32'h0);
    rd(DCC_CTL1_ADDR, 32'h3, 1'b0);
    wr(DCC_CLR_ADDR, 32'h1);
    rd(DCC_STAT_ADDR, 32'h0, 1'b0);
  endtask
  // Power bit, wake from idle, then total power-down
  task automatic s_power;
    wr(DCC_PWR_ADDR, 32'h20);
    repeat (4) @(posedge pclk);
    `CHK(comp_power_off, 1'b1)
    wr(DCC_CTL2_ADDR, 32'h3C);
    repeat (520) @(posedge pclk);
    `CHK(comp_power_off, 1'b0)
    `CHK({comp2_pos_sel, comp2_neg_sel, comp2_pin_en}, 3'h7)
    wr(DCC_CLR_ADDR, 32'h3);
    wr(DCC_IRQEN_ADDR, 32'h3);
    power_mode <= 2'h1;
    repeat (4) @(posedge pclk);
    lvl[1] <= 1'b1;
    wt(1'b1);
    repeat (2) @(posedge pclk);
    `CHK({wake, comp2_enable}, 2'h3)
    wr(DCC_CLR_ADDR, 32'h2);
    wt(1'b0);
    power_mode <= 2'h3;
    repeat (6) @(posedge pclk);
    `CHK({comp2_enable, comp_power_off}, 2'h1)
    rd(DCC_CTL2_ADDR, 32'h1E, 1'b0);
    `CHK(comp2_pin_en, 1'b0)
    power_mode <= 2'h0;
    wr(DCC_PWR_ADDR, 32'h0);
    repeat (6) @(posedge pclk);
    `CHK(comp_power_off, 1'b0)
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    s_reset();
    s_ref();
    s_change();
    s_power();
    conclude();
  end
endmodule // tb
